// File: rst_nmi_map.svh
// Constants for the reset, trap and power-down control block.
`ifndef RST_NMI_MAP_SVH
`define RST_NMI_MAP_SVH
`define CLK_PERIOD_PS 5000
`define SPIKE_REJECT_PS 10000
`define SPIKE_PASS_PS 100000
// Filter length: shortest accepted pulse, rounded down, at least one cycle.
`define FILT_CYCLES ((`SPIKE_PASS_PS / `CLK_PERIOD_PS) > 0 ? (`SPIKE_PASS_PS / `CLK_PERIOD_PS) : 1)
`define RST_SEQ_CYCLES 64
`define CNT_W 8
`define SRC_LONG_HW 2'h0
`define SRC_SHORT_HW 2'h1
`define SRC_SW 2'h2
`define SRC_WDT 2'h3
`endif

// File: rst_nmi_pkg.sv
// Types for the reset, trap and power-down control block.
package rst_nmi_pkg;
  typedef enum {ST_RESET, ST_INIT, ST_RUN, ST_PDOWN} seq_state_t;
  typedef logic [1:0] rst_src_t;
endpackage

// File: rst_spike_filter.sv
// Spike filter for the reset pin: a low must persist to be accepted.
`timescale 1ns/100ps
`include "rst_nmi_map.svh"
module rst_spike_filter (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic pin_i,
  output logic low_o
);
  typedef struct packed {
    logic [2:0] sync;
    logic [`CNT_W-1:0] cnt;
    logic low;
  } filt_state_t;
  filt_state_t s_r;
  filt_state_t s_nxt;
  logic agree_low;

  // Three-stage synchroniser; only stages two and three are compared.
  assign agree_low = ~s_r.sync[1] & ~s_r.sync[2];

  always_comb begin
    s_nxt = s_r;
    s_nxt.sync = {s_r.sync[1:0], pin_i};
    if (agree_low) begin
      // Counting to the pass time rejects spikes and always accepts long lows.
      if (s_r.cnt < `CNT_W'(`FILT_CYCLES - 1)) begin
        s_nxt.cnt = s_r.cnt + `CNT_W'(1);
      end else begin
        s_nxt.low = 1'b1;
      end
    end else begin
      s_nxt.cnt = '0;
      s_nxt.low = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r <= '{sync: 3'h7, cnt: '0, low: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign low_o = s_r.low;

  chk_filter_reject: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(s_r.low) |-> $past(agree_low, 2))
    else $error("Reset low accepted without a stable low.");
endmodule // rst_spike_filter

// File: reset_nmi_powerdown_ctrl.sv
// Reset sequencing, trap request and power-down entry control.
// What this block does
// - A low reset pin while the clock runs resets the device.
// - Reset lows under 10 ns are rejected, over 100 ns plus one clock always accepted.
// - With bidirectional mode set, the device pulls reset low during its sequence.
// - Reset indication goes low on hardware, software or watchdog reset.
// - Reset indication stays low until end of initialisation, then high.
// - A falling edge on the trap pin in the running state (ST_RUN) raises the trap request.
// - Power-down instruction with trap pin low in the running state (ST_RUN) enters power-down.
// - Power-down instruction with trap pin high is ignored.
// - Bidirectional enable locks after end of initialisation; reset clears it.
// - In bidirectional mode the source flags report a long hardware reset.
// - In bidirectional mode a short hardware reset is stretched to the sequence.
`timescale 1ns/100ps
`include "rst_nmi_map.svh"
module reset_nmi_powerdown_ctrl (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic reset_input_pin_i,
  output logic reset_input_pin_o,
  output logic reset_input_pin_oe_o,
  input wire logic nmi_pin_i,
  input wire logic sw_reset_i,
  input wire logic wdt_reset_i,
  input wire logic end_of_init_instruction_i,
  input wire logic power_down_instruction_i,
  input wire logic bidir_reset_enable_wr_i,
  input wire logic bidir_reset_enable_val_i,
  output logic bidir_reset_enable_o,
  output logic reset_indication_output_o,
  output logic core_reset_b_o,
  output logic nmi_trap_o,
  output logic power_down_o,
  output rst_nmi_pkg::rst_src_t reset_source_o
);
  import rst_nmi_pkg::*;

  typedef struct packed {
    logic [1:0] rsync;
    logic [2:0] nsync;
    seq_state_t st;
    logic [`CNT_W-1:0] cnt;
    logic bidir_en;
    logic locked;
    logic reset_indication_output_b;
    logic drive_low;
    logic trap;
    rst_src_t src;
    logic hw_seen;
    // Last agreed trap pin level; it starts high so leaving reset gives no false edge.
    logic nmi_lvl;
  } ctrl_state_t;

  ctrl_state_t s_r;
  ctrl_state_t s_nxt;
  logic rst_int_b;
  logic pin_low;
  logic nmi_low;
  logic any_req;

  rst_spike_filter u_filter (
    .mclk_i(mclk_i),
    .rst_b_i(rst_int_b),
    .pin_i(reset_input_pin_i),
    .low_o(pin_low)
  );

  // Reset release goes through two flops so release is clean to the clock.
  assign rst_int_b = s_r.rsync[1];

  // Trap pin uses stages two and three only; a change counts once they agree.
  assign nmi_low = ~s_r.nsync[1] & ~s_r.nsync[2];
  assign any_req = pin_low | sw_reset_i | wdt_reset_i;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rsync = {s_r.rsync[0], 1'b1};
    s_nxt.nsync = {s_r.nsync[1:0], nmi_pin_i};
    s_nxt.trap = 1'b0;
    if (s_r.nsync[1] == s_r.nsync[2]) begin
      s_nxt.nmi_lvl = s_r.nsync[2];
      // Falling edge of the agreed level requests the trap.
      if (s_r.nmi_lvl && !s_r.nsync[2] && s_r.st == ST_RUN) begin
        s_nxt.trap = 1'b1;
      end
    end
    unique case (s_r.st)
      ST_RESET: begin
        s_nxt.reset_indication_output_b = 1'b0;
        if (pin_low && !s_r.drive_low) begin
          s_nxt.hw_seen = 1'b1;
        end
        if (s_r.cnt < `CNT_W'(`RST_SEQ_CYCLES - 1)) begin
          s_nxt.cnt = s_r.cnt + `CNT_W'(1);
        end else if (s_r.drive_low) begin
          // Our own pull is let go first; its filtered echo on the pin must clear
          // before the sequence ends, or it would look like a fresh board reset.
          s_nxt.drive_low = 1'b0;
          s_nxt.bidir_en = 1'b0;
        end else if (!pin_low) begin
          // Sequence always runs to full length, so short lows are stretched.
          s_nxt.st = ST_INIT;
          s_nxt.bidir_en = 1'b0;
          s_nxt.locked = 1'b0;
          s_nxt.cnt = '0;
        end
      end
      ST_INIT: begin
        if (end_of_init_instruction_i) begin
          s_nxt.reset_indication_output_b = 1'b1;
          s_nxt.locked = 1'b1;
          s_nxt.st = ST_RUN;
        end else if (bidir_reset_enable_wr_i && !s_r.locked) begin
          // Writes are refused once end of initialisation has locked the bit.
          s_nxt.bidir_en = bidir_reset_enable_val_i;
        end
      end
      ST_RUN: begin
        // Low trap pin at the instruction allows power-down, high ignores it.
        if (power_down_instruction_i && nmi_low) begin
          s_nxt.st = ST_PDOWN;
        end
      end
      ST_PDOWN: begin
        s_nxt.st = ST_PDOWN;
      end
    endcase
    // Any reset cause restarts the sequence from any state except ST_RESET, which keeps its count.
    if (any_req && s_r.st != ST_RESET) begin
      s_nxt.st = ST_RESET;
      s_nxt.cnt = '0;
      s_nxt.reset_indication_output_b = 1'b0;
      s_nxt.hw_seen = pin_low;
      s_nxt.drive_low = s_r.bidir_en;
      s_nxt.trap = 1'b0;
      if (s_r.bidir_en) begin
        s_nxt.src = `SRC_LONG_HW;
      end else if (pin_low) begin
        s_nxt.src = `SRC_SHORT_HW;
      end else if (wdt_reset_i) begin
        s_nxt.src = `SRC_WDT;
      end else begin
        s_nxt.src = `SRC_SW;
      end
    end else if (s_r.st == ST_RESET && s_r.hw_seen && !s_r.drive_low && pin_low &&
                 s_r.cnt == `CNT_W'(`RST_SEQ_CYCLES - 1)) begin
      s_nxt.src = `SRC_LONG_HW;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r <= '{rsync: 2'h0, nsync: 3'h7, st: ST_RESET, cnt: '0, bidir_en: 1'b0, locked: 1'b0,
               reset_indication_output_b: 1'b0, drive_low: 1'b0, trap: 1'b0, src: `SRC_LONG_HW, hw_seen: 1'b1,
               nmi_lvl: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reset_input_pin_o = 1'b0;
  assign reset_input_pin_oe_o = s_r.drive_low;
  assign bidir_reset_enable_o = s_r.bidir_en;
  assign reset_indication_output_o = s_r.reset_indication_output_b;
  assign core_reset_b_o = (s_r.st != ST_RESET);
  assign nmi_trap_o = s_r.trap;
  assign power_down_o = (s_r.st == ST_PDOWN);
  assign reset_source_o = s_r.src;

  chk_reset_enters: assert property (@(posedge mclk_i) disable iff (!rst_int_b)
    pin_low |=> s_r.st == ST_RESET)
    else $error("Accepted reset low did not hold the reset state.");
  chk_reset_indication_output_low: assert property (@(posedge mclk_i) disable iff (!rst_int_b)
    (sw_reset_i || wdt_reset_i) |=> !reset_indication_output_o)
    else $error("Reset indication not low after reset request.");
  chk_reset_indication_output_end_of_init_instruction: assert property (@(posedge mclk_i) disable iff (!rst_int_b)
    $rose(reset_indication_output_o) |-> $past(end_of_init_instruction_i))
    else $error("Reset indication rose without end of init.");
  chk_bidir_drive: assert property (@(posedge mclk_i) disable iff (!rst_int_b)
    (s_r.st == ST_RESET && s_r.bidir_en && s_r.cnt > 0) |-> reset_input_pin_oe_o)
    else $error("Bidirectional reset line not driven during sequence.");
  chk_bidir_lock: assert property (@(posedge mclk_i) disable iff (!rst_int_b)
    (s_r.st == ST_RUN && !any_req) |=> $stable(bidir_reset_enable_o))
    else $error("Bidirectional enable changed after end of init.");
  chk_src_long: assert property (@(posedge mclk_i) disable iff (!rst_int_b)
    (any_req && s_r.bidir_en && s_r.st != ST_RESET) |=> reset_source_o == `SRC_LONG_HW)
    else $error("Bidirectional mode did not report long hardware reset.");
  chk_seq_length: assert property (@(posedge mclk_i) disable iff (!rst_int_b)
    $rose(core_reset_b_o) |-> $past(s_r.cnt) == `CNT_W'(`RST_SEQ_CYCLES - 1))
    else $error("Reset sequence ended early.");
  chk_pdown_entry: assert property (@(posedge mclk_i) disable iff (!rst_int_b)
    (s_r.st == ST_RUN && power_down_instruction_i && !nmi_low && !any_req) |=> !power_down_o)
    else $error("Power-down entered with trap pin high.");
  chk_pdown_low: assert property (@(posedge mclk_i) disable iff (!rst_int_b)
    (s_r.st == ST_RUN && power_down_instruction_i && nmi_low && !any_req) |=> power_down_o)
    else $error("Power-down not entered with trap pin low.");
  chk_trap_edge: assert property (@(posedge mclk_i) disable iff (!rst_int_b)
    nmi_trap_o |-> $past(s_r.nmi_lvl) && !$past(s_r.nsync[2]))
    else $error("Trap raised without a falling edge.");
  chk_trap_in_run: assert property (@(posedge mclk_i) disable iff (!rst_int_b)
    nmi_trap_o |-> $past(s_r.st) == ST_RUN)
    else $error("Trap raised outside normal running.");
  chk_drive_in_seq: assert property (@(posedge mclk_i) disable iff (!rst_int_b)
    reset_input_pin_oe_o |-> !core_reset_b_o)
    else $error("Reset line driven outside the reset sequence.");
  chk_bidir_cleared: assert property (@(posedge mclk_i) disable iff (!rst_int_b)
    $fell(reset_input_pin_oe_o) |-> !bidir_reset_enable_o)
    else $error("Bidirectional enable survived its reset.");
  chk_write_locked: assert property (@(posedge mclk_i) disable iff (!rst_int_b)
    (s_r.locked && s_r.st != ST_RESET && !any_req) |=> $stable(bidir_reset_enable_o))
    else $error("Bidirectional enable changed while locked.");
  chk_src_short: assert property (@(posedge mclk_i) disable iff (!rst_int_b)
    (pin_low && !s_r.bidir_en && s_r.st != ST_RESET) |=> reset_source_o == `SRC_SHORT_HW)
    else $error("Board reset not reported as a hardware reset.");

  cov_echo_release: cover property (@(posedge mclk_i) disable iff (!rst_int_b) $fell(reset_input_pin_oe_o));
  cov_bidir_reset: cover property (@(posedge mclk_i) disable iff (!rst_int_b) $rose(reset_input_pin_oe_o));
  cov_trap: cover property (@(posedge mclk_i) disable iff (!rst_int_b) nmi_trap_o);
  cov_pdown: cover property (@(posedge mclk_i) disable iff (!rst_int_b) $rose(power_down_o));
  cov_end_of_init_instruction: cover property (@(posedge mclk_i) disable iff (!rst_int_b) $rose(reset_indication_output_o));
endmodule // reset_nmi_powerdown_ctrl

// File: rst_board_model.sv
// Board model: open-drain reset line with pull-up, and a trap signal source.
`timescale 1ns/100ps
module rst_board_model (
  input wire logic mclk_i,
  input wire logic pin_oe_i,
  output logic pin_o,
  output logic nmi_o
);
  logic ext_low = 1'b0;
  // Either party may pull the line low; otherwise the pull-up wins.
  assign pin_o = (pin_oe_i || ext_low) ? 1'b0 : 1'b1;
  initial nmi_o = 1'b1;
  // A real reset holds the line for at least 100 ns plus two clocks; one cycle models a spike.
  task automatic hold_low(input int n);
    @(posedge mclk_i);
    ext_low <= 1'b1;
    repeat (n) @(posedge mclk_i);
    ext_low <= 1'b0;
  endtask
  task automatic set_nmi(input logic v);
    @(posedge mclk_i);
    nmi_o <= v;
  endtask
endmodule // rst_board_model

// File: test_reset_nmi_powerdown_ctrl.sv
// Self-checking bench for the reset, trap and power-down controller.
`timescale 1ns/100ps
`include "rst_nmi_map.svh"
module test_reset_nmi_powerdown_ctrl;
  import rst_nmi_pkg::*;
  logic mclk_i = 0, rst_b_i = 0, sw_r = 0, wdt_r = 0, eoi = 0, pdi = 0, bwr = 0, bval = 0;
  logic pin_w, nmi_w, oe, pin_o, ben, reset_indication_output, core_b, trap, pdn;
  rst_src_t src;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  always #2.5 mclk_i = ~mclk_i;
  reset_nmi_powerdown_ctrl dut_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .reset_input_pin_i(pin_w),
    .reset_input_pin_o(pin_o), .reset_input_pin_oe_o(oe), .nmi_pin_i(nmi_w), .sw_reset_i(sw_r),
    .wdt_reset_i(wdt_r), .end_of_init_instruction_i(eoi), .power_down_instruction_i(pdi),
    .bidir_reset_enable_wr_i(bwr), .bidir_reset_enable_val_i(bval), .bidir_reset_enable_o(ben),
    .reset_indication_output_o(reset_indication_output), .core_reset_b_o(core_b), .nmi_trap_o(trap),
    .power_down_o(pdn), .reset_source_o(src));
  rst_board_model board_u (.mclk_i(mclk_i), .pin_oe_i(oe), .pin_o(pin_w), .nmi_o(nmi_w));
  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // The ceiling is several times the expected run length.
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD at %0t: saw %b, expected %b", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic wait_seq();
    int k;
    k = 0;
    while (core_b !== 1'b1 && k < 300) begin
      tick(1);
      k++;
    end
    chk(core_b, 1);
  endtask
  task automatic end_init();
    @(posedge mclk_i);
    eoi <= 1'b1;
    @(posedge mclk_i);
    eoi <= 1'b0;
    tick(1);
    chk(reset_indication_output, 1);
  endtask
  task automatic write_bidir(input logic v);
    @(posedge mclk_i);
    bwr <= 1'b1;
    bval <= v;
    @(posedge mclk_i);
    bwr <= 1'b0;
    tick(1);
  endtask
  task automatic t_boot();
    tick(1);
    chk(reset_indication_output, 0);
    wait_seq();
    chk(reset_indication_output, 0);
    write_bidir(1'b1);
    chk(ben, 1);
    end_init();
    write_bidir(1'b0);
    chk(ben, 1);
  endtask
  task automatic t_bidir_sw();
    @(posedge mclk_i);
    sw_r <= 1'b1;
    @(posedge mclk_i);
    sw_r <= 1'b0;
    tick(2);
    chk(reset_indication_output, 0);
    chk(oe, 1);
    chk(pin_o, 0);
    chk(pin_w, 0);
    wait_seq();
    chk(src, `SRC_LONG_HW);
    chk(ben, 0);
    chk(oe, 0);
  endtask
  task automatic t_bidir_short_hw();
    write_bidir(1'b1);
    end_init();
    board_u.hold_low(24);
    tick(30);
    chk(core_b, 0);
    chk(oe, 1);
    wait_seq();
    chk(src, `SRC_LONG_HW);
    end_init();
  endtask
  task automatic t_spike();
    board_u.hold_low(1);
    repeat (30) begin
      tick(1);
      chk({core_b, reset_indication_output}, 2'b11);
    end
  endtask
  // Plain mode: a short and a long board reset, then a software reset.
  task automatic t_plain();
    board_u.hold_low(24);
    tick(30);
    chk({core_b, oe}, 2'b00);
    wait_seq();
    chk(src, `SRC_SHORT_HW);
    end_init();
    board_u.hold_low(100);
    tick(1);
    chk(core_b, 0);
    wait_seq();
    chk(src, `SRC_LONG_HW);
    end_init();
    @(posedge mclk_i);
    sw_r <= 1'b1;
    @(posedge mclk_i);
    sw_r <= 1'b0;
    tick(2);
    chk(reset_indication_output, 0);
    wait_seq();
    chk(src, `SRC_SW);
    end_init();
  endtask
  task automatic t_trap();
    int k;
    k = 0;
    board_u.set_nmi(1'b0);
    while (trap !== 1'b1 && k < 10) begin
      tick(1);
      k++;
    end
    chk(trap, 1);
    tick(1);
    chk(trap, 0);
    board_u.set_nmi(1'b1);
  endtask
  task automatic t_wdt();
    @(posedge mclk_i);
    wdt_r <= 1'b1;
    @(posedge mclk_i);
    wdt_r <= 1'b0;
    tick(2);
    chk({reset_indication_output, oe}, 2'b00);
    wait_seq();
    chk(src, `SRC_WDT);
    end_init();
  endtask
  task automatic pd(input logic nmi_lvl, input logic exp);
    board_u.set_nmi(nmi_lvl);
    tick(4);
    @(posedge mclk_i);
    pdi <= 1'b1;
    @(posedge mclk_i);
    pdi <= 1'b0;
    tick(2);
    chk(pdn, exp);
  endtask
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    t_boot();
    t_bidir_sw();
    t_bidir_short_hw();
    t_spike();
    t_trap();
    t_wdt();
    t_plain();
    pd(1'b1, 1'b0);
    pd(1'b0, 1'b1);
    test_done();
  end
endmodule // test_reset_nmi_powerdown_ctrl
